// ===== design/serial_eeprom_map.svh
// offsets, field values and timing figures of the serial eeprom slave port
`ifndef SERIAL_EEPROM_MAP_SVH
`define SERIAL_EEPROM_MAP_SVH

// select byte layout: four type bits, three chip-select bits, direction bit
`define SEL_TYPE_MSB 7
`define SEL_TYPE_LSB 4
`define SEL_CHIP_MSB 3
`define SEL_CHIP_LSB 1
`define SEL_DIR_BIT 0
`define SEL_CHIP_VALUE 3'h0
`define DIR_READ 1'h1

// bit slots within one byte frame
`define BIT_LAST_DATA 4'h7
`define BIT_ACK_SLOT 4'h8
`define BIT_AFTER_START 4'h2

// address layout
`define ADDR_FULL_W 16
`define PAGE_BITS 6
`define PAGE_BYTES 64

// self-timed programming cycle
`define PROG_TIME_NS 5000000
`define CLK_PERIOD_NS 25

`endif

// ===== design/serial_eeprom_pkg.sv
// types shared by the serial eeprom slave port
package serial_eeprom_pkg;

  // link-side protocol phase, advanced on the serial clock
  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_DEVSEL  = 3'h1,
    ST_ADDR_HI = 3'h2,
    ST_ADDR_LO = 3'h3,
    ST_WDATA   = 3'h4,
    ST_RDATA   = 3'h5,
    ST_RWAIT   = 3'h6
  } link_state_t;

endpackage

// ===== design/serial_eeprom_slave_port.sv
// two-wire slave front end of a byte-organised serial eeprom
`timescale 1ns/1ps
`include "serial_eeprom_map.svh"

// Behaviour
// - power-on reset silences all bus activity
// - start is data falling while clock high
// - stop is data rising while clock high
// - nothing answered until a start is seen
// - read stop after master nack means standby
// - write stop launches the programming cycle
// - receiver pulls data low in ninth slot
// - data sampled on rising serial clock edge
// - select byte msb first, code then direction
// - select code: type field plus zero chip-select
// - direction bit one reads, zero writes
// - match acknowledged, mismatch released and standby
// - write-protect high blocks all array writes
// - floating write-protect reads as low
// - protected writes still ack select and address
// - sixteen-bit address, high byte first
// - top address bits ignored per size variant
// - byte write or page of 64 bytes
// - random and current reads, protect ignored
// - sequential read continues while master acknowledges
// - protect sampled from start to second address
// - page write increments only low six bits
// - programming only for stop right after ack
// - busy programming: no answer, even to polling
module serial_eeprom_slave_port
  import serial_eeprom_pkg::*;
#(
  parameter int ADDR_W = 15,
  parameter logic [3:0] DEV_TYPE = 4'h5, // arbitrary value, set per product
  parameter int PROG_CYCLES = `PROG_TIME_NS / `CLK_PERIOD_NS
) (
  // system clock and internal power-on reset
  input wire logic clk,
  input wire logic arst_n,
  // two-wire link, data pin open drain
  input wire logic scl_clk,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // write-protect pin, pulled low at the pad
  input wire logic write_protect_in,
  // array read side, asynchronous lookup by address
  output logic [ADDR_W-1:0] mem_rd_addr,
  input wire logic [7:0] mem_rd_data,
  // programming side, system clock domain
  output logic prog_start,
  output logic prog_busy,
  output logic [ADDR_W-`PAGE_BITS-1:0] prog_row_addr,
  output logic [`PAGE_BYTES-1:0] prog_mask,
  input wire logic [`PAGE_BITS-1:0] prog_idx,
  output logic [7:0] prog_byte
);

  localparam int CNT_W = $clog2(PROG_CYCLES + 1);

  // only the two size variants are served
  if (!(ADDR_W == 14 || ADDR_W == 15)) begin : g_bad_addr_w
    $error("ADDR_W must be 14 or 15");
  end
  if (PROG_CYCLES < 1) begin : g_bad_prog
    $error("PROG_CYCLES must be at least 1");
  end

  // start and stop capture, clocked by the data line itself
  logic start_tgl_r;
  logic stop_tgl_r;
  // link domain
  logic start_s1_r, start_s2_r, start_s3_r;
  logic stop_s1_r, stop_s2_r, stop_s3_r;
  logic busy_s1_r, busy_s2_r;
  logic wp_s1_r, wp_s2_r;
  logic start_new, stop_new;
  link_state_t state_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] byte_in;
  logic byte_done, ack_slot;
  logic sel_match;
  logic ack_r;
  logic rnw_r;
  logic wp_r;
  logic armed_r;
  logic [`ADDR_FULL_W-1:0] addr_r;
  logic [7:0] page_r [`PAGE_BYTES];
  logic [`PAGE_BYTES-1:0] mask_r;
  logic page_wr;
  logic [7:0] tx_r;
  logic sda_oe_r;
  // system clock domain
  logic stop_c1_r, stop_c2_r, stop_c3_r;
  logic armed_c1_r, armed_c2_r;
  logic stop_evt;
  logic busy_r;
  logic prog_start_r;
  logic [CNT_W-1:0] cnt_r;

  // a start may only be taken while the clock is high; the data edge is the clock here
  always_ff @(negedge sda_i or negedge arst_n) begin
    if (!arst_n) begin
      start_tgl_r <= 1'b0;
    end else if (scl_clk) begin
      start_tgl_r <= ~start_tgl_r;
    end
  end

  // stop mirrors the start on the rising data edge
  always_ff @(posedge sda_i or negedge arst_n) begin
    if (!arst_n) begin
      stop_tgl_r <= 1'b0;
    end else if (scl_clk) begin
      stop_tgl_r <= ~stop_tgl_r;
    end
  end

  // first crossing stage on the falling clock, the toggles settle during clock high
  always_ff @(negedge scl_clk or negedge arst_n) begin
    if (!arst_n) begin
      start_s1_r <= 1'b0;
      stop_s1_r <= 1'b0;
    end else begin
      start_s1_r <= start_tgl_r;
      stop_s1_r <= stop_tgl_r;
    end
  end

  // remaining crossing stages and pin synchronisers on the rising clock
  always_ff @(posedge scl_clk or negedge arst_n) begin
    if (!arst_n) begin
      start_s2_r <= 1'b0;
      start_s3_r <= 1'b0;
      stop_s2_r <= 1'b0;
      stop_s3_r <= 1'b0;
      busy_s1_r <= 1'b0;
      busy_s2_r <= 1'b0;
      wp_s1_r <= 1'b0;
      wp_s2_r <= 1'b0;
    end else begin
      start_s2_r <= start_s1_r;
      start_s3_r <= start_s2_r;
      stop_s2_r <= stop_s1_r;
      stop_s3_r <= stop_s2_r;
      busy_s1_r <= busy_r;
      busy_s2_r <= busy_s1_r;
      wp_s1_r <= write_protect_in;
      wp_s2_r <= wp_s1_r;
    end
  end

  // the start is seen one bit late, so the first select bit already sits in the shifter
  assign start_new = start_s2_r ^ start_s3_r;
  assign stop_new = stop_s2_r ^ stop_s3_r;
  assign byte_in = {shift_r[6:0], sda_i};
  assign byte_done = (bit_cnt_r == `BIT_LAST_DATA);
  assign ack_slot = (bit_cnt_r == `BIT_ACK_SLOT);
  assign sel_match = (byte_in[`SEL_TYPE_MSB:`SEL_TYPE_LSB] == DEV_TYPE) &&
                     (byte_in[`SEL_CHIP_MSB:`SEL_CHIP_LSB] == `SEL_CHIP_VALUE);
  assign page_wr = (state_r == ST_WDATA) && ack_slot && ack_r && !start_new;

  // serial shifter runs on every rising edge, msb arrives first
  always_ff @(posedge scl_clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_r <= 8'h00;
    end else begin
      shift_r <= byte_in;
    end
  end

  // protocol phase and bit slot; a start always wins over a stop
  always_ff @(posedge scl_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
    end else if (start_new) begin
      state_r <= ST_DEVSEL;
      bit_cnt_r <= `BIT_AFTER_START;
    end else if (stop_new) begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
    end else begin
      unique case (state_r)
        ST_IDLE, ST_RWAIT: begin
          bit_cnt_r <= 4'h0;
        end
        ST_DEVSEL: begin
          bit_cnt_r <= ack_slot ? 4'h0 : bit_cnt_r + 4'h1;
          if (ack_slot) begin
            // a refused select detaches until the next start
            state_r <= !ack_r ? ST_IDLE : (rnw_r ? ST_RDATA : ST_ADDR_HI);
          end
        end
        ST_ADDR_HI: begin
          bit_cnt_r <= ack_slot ? 4'h0 : bit_cnt_r + 4'h1;
          if (ack_slot) begin
            state_r <= ST_ADDR_LO;
          end
        end
        ST_ADDR_LO: begin
          bit_cnt_r <= ack_slot ? 4'h0 : bit_cnt_r + 4'h1;
          if (ack_slot) begin
            state_r <= ST_WDATA;
          end
        end
        ST_WDATA: begin
          bit_cnt_r <= ack_slot ? 4'h0 : bit_cnt_r + 4'h1;
        end
        ST_RDATA: begin
          bit_cnt_r <= ack_slot ? 4'h0 : bit_cnt_r + 4'h1;
          if (ack_slot && sda_i) begin
            state_r <= ST_RWAIT;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          bit_cnt_r <= 4'h0;
        end
      endcase
    end
  end

  // acknowledge decision, taken when the eighth bit lands
  always_ff @(posedge scl_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_r <= 1'b0;
      rnw_r <= 1'b0;
    end else if (start_new) begin
      ack_r <= 1'b0;
    end else if (byte_done) begin
      unique case (state_r)
        ST_DEVSEL: begin
          ack_r <= sel_match && !busy_s2_r;
          rnw_r <= (byte_in[`SEL_DIR_BIT] == `DIR_READ);
        end
        ST_ADDR_HI, ST_ADDR_LO: begin
          ack_r <= 1'b1;
        end
        ST_WDATA: begin
          ack_r <= !wp_r;
        end
        default: begin
          ack_r <= 1'b0;
        end
      endcase
    end
  end

  // protect level gathered from start to the end of the second address byte
  always_ff @(posedge scl_clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_r <= 1'b0;
    end else if (start_new) begin
      wp_r <= wp_s2_r;
    end else if (state_r inside {ST_DEVSEL, ST_ADDR_HI, ST_ADDR_LO}) begin
      wp_r <= wp_r | wp_s2_r;
    end
  end

  // address counter; only full 16 bits kept, the top bits just never leave the block
  always_ff @(posedge scl_clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_r <= 16'h0000;
    end else if (!start_new && byte_done && state_r == ST_ADDR_HI) begin
      addr_r[15:8] <= byte_in;
    end else if (!start_new && byte_done && state_r == ST_ADDR_LO) begin
      addr_r[7:0] <= byte_in;
    end else if (page_wr) begin
      addr_r[`PAGE_BITS-1:0] <= addr_r[`PAGE_BITS-1:0] + 6'h01;
    end else if (!start_new && ack_slot && state_r == ST_RDATA) begin
      addr_r <= addr_r + 16'h0001;
    end
  end

  // ack of a written data byte arms programming; kept only through the following slot
  always_ff @(posedge scl_clk or negedge arst_n) begin
    if (!arst_n) begin
      armed_r <= 1'b0;
    end else if (start_new) begin
      armed_r <= 1'b0;
    end else if (page_wr) begin
      armed_r <= 1'b1;
    end else if (bit_cnt_r != 4'h0) begin
      armed_r <= 1'b0;
    end
  end

  // page latches; a row overrun overwrites earlier bytes of the same row
  always_ff @(posedge scl_clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_r <= '0;
    end else if (!start_new && byte_done && state_r == ST_DEVSEL && sel_match &&
                 !busy_s2_r && byte_in[`SEL_DIR_BIT] != `DIR_READ) begin
      mask_r <= '0;
    end else if (page_wr) begin
      mask_r[addr_r[`PAGE_BITS-1:0]] <= 1'b1;
    end
  end

  for (genvar i = 0; i < `PAGE_BYTES; i++) begin : g_page
    always_ff @(posedge scl_clk or negedge arst_n) begin
      if (!arst_n) begin
        page_r[i] <= 8'h00;
      end else if (page_wr && addr_r[`PAGE_BITS-1:0] == 6'(i)) begin
        page_r[i] <= shift_r;
      end
    end
  end

  // data pin driven on the falling clock so it is stable across the next rising edge
  always_ff @(negedge scl_clk or negedge arst_n) begin
    if (!arst_n) begin
      sda_oe_r <= 1'b0;
      tx_r <= 8'h00;
    end else if (state_r == ST_RDATA && bit_cnt_r == 4'h0) begin
      tx_r <= mem_rd_data;
      sda_oe_r <= ~mem_rd_data[7];
    end else if (state_r == ST_RDATA && bit_cnt_r < `BIT_ACK_SLOT) begin
      sda_oe_r <= ~tx_r[3'(4'h7 - bit_cnt_r)];
    end else if (ack_slot && ack_r &&
                 state_r inside {ST_DEVSEL, ST_ADDR_HI, ST_ADDR_LO, ST_WDATA}) begin
      sda_oe_r <= 1'b1;
    end else begin
      sda_oe_r <= 1'b0;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe = sda_oe_r;
  assign mem_rd_addr = addr_r[ADDR_W-1:0];
  assign prog_row_addr = addr_r[ADDR_W-1:`PAGE_BITS];
  assign prog_mask = mask_r;
  // page latches are static while busy, so the system side may read them freely
  assign prog_byte = page_r[prog_idx];

  // stop event and armed level brought into the system clock
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stop_c1_r <= 1'b0;
      stop_c2_r <= 1'b0;
      stop_c3_r <= 1'b0;
      armed_c1_r <= 1'b0;
      armed_c2_r <= 1'b0;
    end else begin
      stop_c1_r <= stop_tgl_r;
      stop_c2_r <= stop_c1_r;
      stop_c3_r <= stop_c2_r;
      armed_c1_r <= armed_r;
      armed_c2_r <= armed_c1_r;
    end
  end

  assign stop_evt = stop_c2_r ^ stop_c3_r;

  // self-timed programming cycle; the link refuses select bytes meanwhile
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_r <= 1'b0;
      cnt_r <= '0;
      prog_start_r <= 1'b0;
    end else begin
      prog_start_r <= 1'b0;
      if (!busy_r && stop_evt && armed_c2_r) begin
        busy_r <= 1'b1;
        cnt_r <= CNT_W'(PROG_CYCLES - 1);
        prog_start_r <= 1'b1;
      end else if (busy_r && cnt_r == '0) begin
        busy_r <= 1'b0;
      end else if (busy_r) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  assign prog_start = prog_start_r;
  assign prog_busy = busy_r;

  // link-side checks
  a_ack_drive: assert property (@(posedge scl_clk) disable iff (!arst_n)
    (ack_slot && ack_r && state_r inside {ST_DEVSEL, ST_ADDR_HI, ST_ADDR_LO, ST_WDATA})
    |-> sda_oe) else $error("ack slot not driven low");
  a_wp_nack: assert property (@(posedge scl_clk) disable iff (!arst_n)
    (state_r == ST_WDATA && wp_r && ack_slot) |-> !sda_oe)
    else $error("protected data byte acknowledged");
  a_busy_nack: assert property (@(posedge scl_clk) disable iff (!arst_n)
    (state_r == ST_DEVSEL && ack_slot && $past(busy_s2_r)) |-> !sda_oe)
    else $error("select answered while programming");
  a_idle_quiet: assert property (@(posedge scl_clk) disable iff (!arst_n)
    (state_r == ST_IDLE && $past(state_r) == ST_IDLE) |-> !sda_oe)
    else $error("data driven while idle");
  a_page_wrap: assert property (@(posedge scl_clk) disable iff (!arst_n)
    page_wr |=> (addr_r[15:6] == $past(addr_r[15:6]) &&
                 addr_r[5:0] == $past(addr_r[5:0]) + 6'h01))
    else $error("page address left its row");
  a_read_incr: assert property (@(posedge scl_clk) disable iff (!arst_n)
    (state_r == ST_RDATA && ack_slot && !start_new) |=> addr_r == $past(addr_r) + 16'h0001)
    else $error("read did not advance address");
  a_read_stop: assert property (@(posedge scl_clk) disable iff (!arst_n)
    (state_r == ST_RDATA && ack_slot && sda_i && !start_new && !stop_new) |=>
    (state_r == ST_RWAIT && !sda_oe)) else $error("master nack did not end read");

  // system-side checks
  a_prog_cause: assert property (@(posedge clk) disable iff (!arst_n)
    prog_start |-> (busy_r && $past(armed_c2_r) && !$past(busy_r)))
    else $error("programming started without armed stop");
  a_busy_hold: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(busy_r) |-> $past(cnt_r) == '0)
    else $error("programming cycle ended early");

  c_prog: cover property (@(posedge clk) disable iff (!arst_n) prog_start);
  c_read_nack: cover property (@(posedge scl_clk) disable iff (!arst_n)
    state_r == ST_RDATA ##1 state_r == ST_RWAIT);
  c_wp_nack: cover property (@(posedge scl_clk) disable iff (!arst_n)
    state_r == ST_WDATA && wp_r && ack_slot);
  c_poll_refused: cover property (@(posedge scl_clk) disable iff (!arst_n)
    state_r == ST_DEVSEL && ack_slot && busy_s2_r);

endmodule

// ===== dv/serial_link_master.sv
// two-wire bus master model that drives the eeprom slave port
`timescale 1ns/1ps
module serial_link_master (
  // serial clock, stands high between frames
  output logic scl_clk,
  // open-drain pull on the data wire, high pulls it low
  output logic sda_low,
  // resolved data wire
  input wire logic sda_wire
);
  // stretches the low half of each slot to model a slow master
  int pace = 1;

  // bus idle: both lines released
  initial begin
    scl_clk = 1'b1;
    sda_low = 1'b0;
  end

  // one bit slot; data moves only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    #(12 * pace) sda_low = ~b;
    #(12 * pace) scl_clk = 1'b1;
    #12 r = sda_wire;
    #12 scl_clk = 1'b0;
  endtask

  // start or repeated start: data falls while the clock is high
  task automatic start_cond();
    #12 sda_low = 1'b0;
    #12 scl_clk = 1'b1;
    #12 sda_low = 1'b1;
    #12 scl_clk = 1'b0;
  endtask

  // stop: data rises while the clock is high, clock then stays high
  task automatic stop_cond();
    #12 sda_low = 1'b1;
    #12 scl_clk = 1'b1;
    #12 sda_low = 1'b0;
    #12;
  endtask

  // msb first, then the ninth slot released for the answer
  task automatic put_byte(input logic [7:0] b, output logic ack_n);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, ack_n);
  endtask

  // read a byte with data released, then ack to continue or nack to end
  task automatic get_byte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~more, r);
  endtask
endmodule

// ===== dv/serial_eeprom_slave_port_bench.sv
// self-checking bench for the serial eeprom slave port
`timescale 1ns/1ps
module serial_eeprom_slave_port_bench;
  import serial_eeprom_pkg::*;
  localparam int AW = 15;
  localparam int PCYC = 100;
  localparam logic [3:0] DTYPE = 4'h5; // arbitrary type code
  localparam logic [7:0] SEL_W = {DTYPE, 3'h0, 1'h0};
  localparam logic [7:0] SEL_R = {DTYPE, 3'h0, 1'h1};

  logic clk = 1'b0;
  logic arst_n = 1'b1;
  logic write_protect_in = 1'b0;
  logic [5:0] prog_idx = 6'h00;
  logic scl_clk, sda_low, sda_o, sda_oe, sda_wire, prog_start, prog_busy;
  logic [AW-1:0] mem_rd_addr;
  logic [7:0] mem_rd_data, prog_byte;
  logic [AW-7:0] prog_row_addr;
  logic [63:0] prog_mask;
  int num_errors = 0;
  int num_checks = 0;
  int starts = 0;

  // system clock
  always #12.5 clk = ~clk;

  // pull-up wins unless a party pulls low; array byte follows its address
  assign sda_wire = ~sda_low & ~(sda_oe & ~sda_o);
  assign mem_rd_data = mem_rd_addr[7:0] + 8'h3C;

  // count launches, the pulse is only one clock wide
  always @(posedge clk) begin
    if (prog_start === 1'b1) starts <= starts + 1;
  end

  serial_eeprom_slave_port #(.ADDR_W(AW), .DEV_TYPE(DTYPE), .PROG_CYCLES(PCYC)) dut_u (
    .clk(clk), .arst_n(arst_n), .scl_clk(scl_clk), .sda_i(sda_wire), .sda_o(sda_o),
    .sda_oe(sda_oe), .write_protect_in(write_protect_in), .mem_rd_addr(mem_rd_addr),
    .mem_rd_data(mem_rd_data), .prog_start(prog_start), .prog_busy(prog_busy),
    .prog_row_addr(prog_row_addr), .prog_mask(prog_mask), .prog_idx(prog_idx),
    .prog_byte(prog_byte)
  );

  serial_link_master mdl_u (.scl_clk(scl_clk), .sda_low(sda_low), .sda_wire(sda_wire));

  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t ns: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // inputs move a fixed 2 ns after the rising edge
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic send(input logic [7:0] b, input logic ack_n);
    logic r;
    mdl_u.put_byte(b, r);
    check(64'(r), 64'(ack_n), "ack slot");
  endtask

  // start, write select and both address bytes, all acknowledged
  task automatic head(input logic [15:0] a);
    mdl_u.start_cond();
    send(SEL_W, 1'b0);
    send(a[15:8], 1'b0);
    send(a[7:0], 1'b0);
  endtask

  // bounded wait for the programming cycle to finish
  task automatic wait_idle();
    int n;
    n = 0;
    while (prog_busy !== 1'b0 && n < PCYC + 50) begin
      wait_clk(1);
      n++;
    end
    check(64'(prog_busy), 64'h0, "busy ends");
  endtask

  task automatic t_bad_select();
    logic [7:0] codes [3] = '{{DTYPE, 3'h1, 1'h0}, {4'h4, 3'h0, 1'h1}, {DTYPE, 3'h4, 1'h1}};
    foreach (codes[i]) begin
      mdl_u.start_cond();
      send(codes[i], 1'b1);
      send(SEL_W, 1'b1);
      mdl_u.stop_cond();
    end
  endtask

  // protect level during the header governs, even if dropped before the data
  task automatic t_byte_write(input logic wp, input int pace);
    int s0;
    s0 = starts;
    mdl_u.pace = pace;
    write_protect_in = wp;
    head(16'hC0BE);
    write_protect_in = 1'b0;
    send(8'h96, wp);
    mdl_u.stop_cond();
    mdl_u.pace = 1;
    wait_clk(20);
    check(64'(starts - s0), wp ? 64'h0 : 64'h1, "launch count");
    if (!wp) begin
      mdl_u.start_cond();
      send(SEL_W, 1'b1);
      mdl_u.stop_cond();
      wait_clk(1);
      prog_idx = 6'h3E;
      wait_clk(1);
      check(64'(prog_row_addr), 64'h102, "row");
      check(prog_mask, 64'h1 << 62, "mask");
      check(64'(prog_byte), 64'h96, "latched byte");
      wait_idle();
    end
  endtask

  task automatic t_late_stop();
    int s0;
    logic r;
    s0 = starts;
    head(16'h0200);
    send(8'h5A, 1'b0);
    repeat (3) mdl_u.bit_io(1'b0, r);
    mdl_u.stop_cond();
    wait_clk(20);
    check(64'(starts - s0), 64'h0, "stop off the ack slot");
  endtask

  // second reset in mid-run: a select byte must go unanswered
  task automatic t_reset();
    wait_clk(1);
    arst_n = 1'b0;
    mdl_u.start_cond();
    send(SEL_W, 1'b1);
    mdl_u.stop_cond();
    check(64'(sda_oe), 64'h0, "released in reset");
    wait_clk(1);
    arst_n = 1'b1;
    wait_clk(4);
  endtask

  // three bytes from slot 62 must wrap to slot 0 of the same row
  task automatic t_page();
    int s0;
    s0 = starts;
    head(16'h013E);
    send(8'h11, 1'b0);
    send(8'h22, 1'b0);
    send(8'h33, 1'b0);
    mdl_u.stop_cond();
    wait_clk(20);
    prog_idx = 6'h00;
    wait_clk(1);
    check(prog_mask, 64'hC000_0000_0000_0001, "page mask");
    check(64'(prog_byte), 64'h33, "wrapped byte");
    check(64'(prog_row_addr), 64'h4, "page row");
    check(64'(starts - s0), 64'h1, "page launch");
    wait_idle();
  endtask

  // random then sequential read with protect high, then a current read
  task automatic t_read();
    logic [7:0] d;
    write_protect_in = 1'b1;
    head(16'h8123);
    mdl_u.start_cond();
    send(SEL_R, 1'b0);
    for (int i = 0; i < 3; i++) begin
      mdl_u.get_byte(i < 2, d);
      check(64'(d), 64'(8'h5F + i), "sequential byte");
    end
    mdl_u.stop_cond();
    mdl_u.start_cond();
    send(SEL_R, 1'b0);
    mdl_u.get_byte(1'b0, d);
    check(64'(d), 64'h62, "current address byte");
    mdl_u.stop_cond();
    write_protect_in = 1'b0;
  endtask

  // main sequence
  initial begin
    // a declared start value raises no edge, so the link-side flops need a real fall
    #2 arst_n = 1'b0;
    wait_clk(20);
    arst_n = 1'b1;
    wait_clk(4);
    t_bad_select();
    t_byte_write(1'b0, 3);
    t_byte_write(1'b1, 1);
    t_late_stop();
    t_reset();
    t_page();
    t_read();
    close_out();
  end

  // watchdog: over ten times the expected run of about 25 us
  initial begin
    #400000;
    num_errors++;
    close_out();
  end
endmodule
